// [synth_cfg_pkg.sv]
// constants for the synthesizer control word host
package synth_cfg_pkg;
    localparam logic [3:0] SEL_WORD0 = 4'h0;
    localparam logic [3:0] SEL_MAIN_FRAC = 4'h1;
    localparam logic [3:0] SEL_AUX_FRAC = 4'h2;
    localparam logic [3:0] SEL_PHASE = 4'h3;
    localparam logic [3:0] SEL_REF_PUMP = 4'h4;
    localparam int WORD_BITS = 32;
    localparam int SEL_LSB = 0;
    localparam int FIELD_LSB = 4;
    localparam int MAIN_NUM_BITS = 24;
    localparam int AUX_BITS = 14;
    localparam int AUX_MOD_LSB = 4;
    localparam int AUX_NUM_LSB = 18;
    localparam logic [13:0] AUX_MOD_MIN = 14'h0002;
    localparam int PHASE_BITS = 24;
    localparam int PH_SD_DIS_BIT = 30;
    localparam int PH_RESYNC_BIT = 29;
    localparam int PH_ADJ_BIT = 28;
    localparam int REF_MUX_LSB = 27;
    localparam int REF_DBL_BIT = 26;
    localparam int REF_HALF_BIT = 25;
    localparam int REF_CNT_LSB = 15;
    localparam int REF_CNT_BITS = 10;
    localparam logic [9:0] REF_CNT_MIN = 10'h001;
    localparam int REF_DBUF_BIT = 14;
    localparam int REF_CP_LSB = 10;
    localparam int REF_MODE_BIT = 9;
    localparam int REF_LVL_BIT = 8;
    localparam int REF_POL_BIT = 7;
    localparam int REF_PD_BIT = 6;
    localparam int REF_TRI_BIT = 5;
    localparam int REF_CRST_BIT = 4;
    localparam logic [2:0] MUX_FEEDBACK_DIV = 3'h4;
    localparam logic [2:0] MUX_REF_DIV = 3'h3;
    localparam int SCLK_NS = 50;
    localparam int CLK_NS = 10;
    localparam int SCLK_HALF = (SCLK_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
    localparam logic [5:0] BIT_COUNT = 6'h20;
endpackage

// [word_assembler.sv]
// assembles a 32-bit word from a select code and field values
`timescale 1ns/1ps
module word_assembler (
    input wire logic [3:0] sel,
    input wire logic [27:0] field,
    output logic [31:0] word
);
    // field sits above the four select bits; top reserved bits come in as zero
    assign word = {field, sel};
endmodule // word_assembler

// [serial_shifter.sv]
// three-wire serial shifter, msb first, load strobe at the end
`timescale 1ns/1ps
module serial_shifter (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [31:0] word,
    output logic busy,
    output logic sclk,
    output logic sdata,
    output logic sload
);
    typedef enum {IDLE, LOW, HIGH, LOAD} shift_e;
    shift_e state;
    logic [31:0] shreg;
    logic [5:0] nbits;
    logic [7:0] tick;
    wire tick_done = (tick == 8'(synth_cfg_pkg::SCLK_HALF - 1));

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= IDLE;
            shreg <= 32'h0;
            nbits <= 6'h0;
            tick <= 8'h0;
            busy <= 1'b0;
            sclk <= 1'b0;
            sdata <= 1'b0;
            sload <= 1'b0;
        end
        else
        begin
            tick <= tick_done ? 8'h0 : tick + 8'h1;
            case (state)
                IDLE:
                begin
                    sload <= 1'b0;
                    tick <= 8'h0;
                    if (start)
                    begin
                        shreg <= {word[30:0], 1'b0};
                        sdata <= word[31];
                        nbits <= 6'h0;
                        busy <= 1'b1;
                        state <= LOW;
                    end
                    else
                        busy <= 1'b0;
                end
                LOW:
                    if (tick_done)
                    begin
                        sclk <= 1'b1; // device samples on rising edge
                        nbits <= nbits + 6'h1;
                        state <= HIGH;
                    end
                HIGH:
                    if (tick_done)
                    begin
                        sclk <= 1'b0;
                        if (nbits == synth_cfg_pkg::BIT_COUNT)
                        begin
                            sload <= 1'b1;
                            state <= LOAD;
                        end
                        else
                        begin
                            sdata <= shreg[31];
                            shreg <= {shreg[30:0], 1'b0};
                            state <= LOW;
                        end
                    end
                LOAD:
                    if (tick_done)
                    begin
                        sload <= 1'b0;
                        busy <= 1'b0;
                        state <= IDLE;
                    end
                default:
                    state <= IDLE;
            endcase
        end
    end

    a_load_after_bits: assert property (@(posedge clk) disable iff (srst)
        $rose(sload) |-> nbits == synth_cfg_pkg::BIT_COUNT)
        else $error("load strobe before all bits shifted");
    a_load_clock_low: assert property (@(posedge clk) disable iff (srst)
        sload |-> !sclk)
        else $error("serial clock high during load");
endmodule // serial_shifter

// [synth_cfg_host.sv]
// host controller writing synthesizer control words zero to four
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module synth_cfg_host (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic REQ_VALID,
    input wire logic [2:0] REQ_KIND,
    input wire logic [23:0] MAIN_NUM,
    input wire logic [23:0] MAIN_MOD,
    input wire logic [13:0] AUX_NUM,
    input wire logic [13:0] AUX_MOD,
    input wire logic [23:0] PHASE_VAL,
    input wire logic SD_DIS,
    input wire logic RESYNC_EN,
    input wire logic ADJ_EN,
    input wire logic AUTO_CAL,
    input wire logic [2:0] MUX_SEL,
    input wire logic DOUBLER,
    input wire logic HALVER,
    input wire logic [9:0] REF_COUNT,
    input wire logic DBUF,
    input wire logic [3:0] PUMP_CUR,
    input wire logic REF_DIFF,
    input wire logic LEVEL_33,
    input wire logic POWER_DOWN,
    input wire logic PUMP_TRI,
    input wire logic COUNTER_RST,
    input wire logic [27:0] WORD0_FIELD,
    output logic REQ_READY,
    output logic REQ_DONE,
    output logic REQ_ERROR,
    output logic SCLK,
    output logic SDATA,
    output logic SLOAD
);
    localparam logic [2:0] K_WORD0 = 3'h0;
    localparam logic [2:0] K_MAIN = 3'h1;
    localparam logic [2:0] K_AUX = 3'h2;
    localparam logic [2:0] K_PHASE = 3'h3;
    localparam logic [2:0] K_REF = 3'h4;

    typedef enum {IDLE, SEND, WAIT} host_e;
    host_e state;
    logic start;
    logic [31:0] held_word;
    logic [2:0] held_kind;
    logic busy;
    logic sclk_i;
    logic sdata_i;
    logic sload_i;
    // last sent phase settings, aux numerator and mux code, used to vet later requests
    logic sd_dis_sent;
    logic resync_sent;
    logic adj_sent;
    logic [13:0] aux_num_sent;
    logic [2:0] mux_sent;

    ////////////////////////////////////////////////////////////////////////////
    // field assembly
    wire [3:0] sel = (REQ_KIND == K_MAIN) ? synth_cfg_pkg::SEL_MAIN_FRAC :
                     (REQ_KIND == K_AUX) ? synth_cfg_pkg::SEL_AUX_FRAC :
                     (REQ_KIND == K_PHASE) ? synth_cfg_pkg::SEL_PHASE :
                     (REQ_KIND == K_REF) ? synth_cfg_pkg::SEL_REF_PUMP :
                     synth_cfg_pkg::SEL_WORD0;
    wire [27:0] f_main = {4'h0, MAIN_NUM};
    wire [27:0] f_aux = {AUX_NUM, AUX_MOD};
    wire [27:0] f_phase = {1'b0, SD_DIS, RESYNC_EN, ADJ_EN, PHASE_VAL};
    // reference word: fields above select bits, index shifted down by four
    wire [27:0] f_ref = {2'h0, MUX_SEL, DOUBLER, HALVER, REF_COUNT, DBUF, PUMP_CUR,
                         REF_DIFF, LEVEL_33, 1'b1, POWER_DOWN, PUMP_TRI, COUNTER_RST};
    wire [27:0] field = (REQ_KIND == K_MAIN) ? f_main :
                        (REQ_KIND == K_AUX) ? f_aux :
                        (REQ_KIND == K_PHASE) ? f_phase :
                        (REQ_KIND == K_REF) ? f_ref :
                        WORD0_FIELD;
    wire [31:0] word;

    word_assembler u_asm (
        .sel(sel),
        .field(field),
        .word(word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request checks; refused requests never reach the pins
    wire bad_kind = (REQ_KIND > K_REF);
    wire bad_main = (REQ_KIND == K_MAIN) && (MAIN_NUM >= MAIN_MOD);
    wire bad_aux = (REQ_KIND == K_AUX) &&
                   ((AUX_MOD < synth_cfg_pkg::AUX_MOD_MIN) || (AUX_NUM >= AUX_MOD) ||
                    (resync_sent && (AUX_NUM != 14'h0)));
    wire bad_phase = (REQ_KIND == K_PHASE) &&
                     ((RESYNC_EN && (SD_DIS || ADJ_EN || aux_num_sent != 14'h0)) ||
                      (ADJ_EN && !SD_DIS));
    wire bad_ref = (REQ_KIND == K_REF) && (REF_COUNT < synth_cfg_pkg::REF_CNT_MIN);
    // word zero write: retune must not run with divider test output,
    // and adjust mode wants calibration off
    wire bad_w0 = (REQ_KIND == K_WORD0) &&
                  ((mux_sent == synth_cfg_pkg::MUX_FEEDBACK_DIV) || (mux_sent == synth_cfg_pkg::MUX_REF_DIV) ||
                   (adj_sent && AUTO_CAL));
    wire refuse = bad_kind || bad_main || bad_aux || bad_phase || bad_ref || bad_w0;
    wire take = REQ_VALID && REQ_READY;

    ////////////////////////////////////////////////////////////////////////////
    // control
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state <= IDLE;
            start <= 1'b0;
            held_word <= 32'h0;
            held_kind <= 3'h0;
            REQ_READY <= 1'b0;
            REQ_DONE <= 1'b0;
            REQ_ERROR <= 1'b0;
        end
        else
        begin
            REQ_DONE <= 1'b0;
            REQ_ERROR <= 1'b0;
            start <= 1'b0;
            case (state)
                IDLE:
                begin
                    REQ_READY <= 1'b1;
                    if (take)
                    begin
                        REQ_READY <= 1'b0;
                        if (refuse)
                        begin
                            REQ_ERROR <= 1'b1;
                            REQ_DONE <= 1'b1;
                        end
                        else
                        begin
                            held_word <= word;
                            held_kind <= REQ_KIND;
                            start <= 1'b1;
                            state <= SEND;
                        end
                    end
                end
                SEND:
                    if (busy)
                        state <= WAIT;
                WAIT:
                    if (!busy)
                    begin
                        REQ_DONE <= 1'b1;
                        REQ_READY <= 1'b1;
                        state <= IDLE;
                    end
                default:
                    state <= IDLE;
            endcase
        end
    end

    // shadow of settings the device now holds
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sd_dis_sent <= 1'b0;
            resync_sent <= 1'b0;
            adj_sent <= 1'b0;
            aux_num_sent <= 14'h0;
            mux_sent <= 3'h0;
        end
        else if (take && !refuse)
        begin
            if (REQ_KIND == K_PHASE)
            begin
                sd_dis_sent <= SD_DIS;
                resync_sent <= RESYNC_EN;
                adj_sent <= ADJ_EN;
            end
            if (REQ_KIND == K_AUX)
                aux_num_sent <= AUX_NUM;
            if (REQ_KIND == K_REF)
                mux_sent <= MUX_SEL;
        end
    end

    serial_shifter u_shift (
        .clk(CLK),
        .srst(SRST),
        .start(start),
        .word(held_word),
        .busy(busy),
        .sclk(sclk_i),
        .sdata(sdata_i),
        .sload(sload_i)
    );

    // pins registered once more so top outputs come from flops
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            SCLK <= 1'b0;
            SDATA <= 1'b0;
            SLOAD <= 1'b0;
        end
        else
        begin
            SCLK <= sclk_i;
            SDATA <= sdata_i;
            SLOAD <= sload_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_main_reserved: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_MAIN_FRAC |-> held_word[31:28] == 4'h0)
        else $error("main fraction reserved bits not zero");
    a_ref_polarity: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_REF_PUMP |-> held_word[7] && held_word[31:30] == 2'h0)
        else $error("reference word polarity or reserved bits wrong");
    a_phase_reserved: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_PHASE |-> !held_word[31])
        else $error("phase word reserved bit set");
    a_aux_modulus: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_AUX_FRAC |-> held_word[17:4] >= 14'h0002)
        else $error("aux modulus below two");
    a_aux_order: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_AUX_FRAC |-> held_word[31:18] < held_word[17:4])
        else $error("aux numerator not below modulus");
    a_select_code: assert property (@(posedge CLK) disable iff (SRST)
        start && held_kind == K_MAIN |-> held_word[3:0] == 4'h1)
        else $error("main fraction select wrong");
    a_phase_modes: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_PHASE |-> !(held_word[29] && held_word[28]))
        else $error("resync and adjust both set");
    a_ref_counter: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_REF_PUMP |-> held_word[24:15] != 10'h0)
        else $error("reference counter zero");
    a_start_answer: assert property (@(posedge CLK) disable iff (SRST)
        start |-> ##[1:3] busy)
        else $error("shifter did not start");

    ////////////////////////////////////////////////////////////////////////////
    // handshake, pin and request rule checks
    // pins lag the shifter by one flop, so load and clock keep their order
    a_error_with_done: assert property (@(posedge CLK) disable iff (SRST)
        REQ_ERROR |-> REQ_DONE)
        else $error("error pulse without done");
    a_ready_when_idle: assert property (@(posedge CLK) disable iff (SRST)
        REQ_READY |-> !busy && !start)
        else $error("ready while a word is in flight");
    a_refused_quiet: assert property (@(posedge CLK) disable iff (SRST)
        REQ_ERROR |-> !start)
        else $error("refused request started the shifter");
    a_ready_after_done: assert property (@(posedge CLK) disable iff (SRST)
        REQ_DONE && !REQ_ERROR |-> REQ_READY)
        else $error("ready not back with done");
    a_pin_load_order: assert property (@(posedge CLK) disable iff (SRST)
        SLOAD |-> !SCLK)
        else $error("load pin high with serial clock high");
    a_load_pin_width: assert property (@(posedge CLK) disable iff (SRST)
        $rose(SLOAD) |-> SLOAD [*3])
        else $error("load pin shorter than a half period");
    a_data_steady: assert property (@(posedge CLK) disable iff (SRST)
        $rose(SCLK) |-> $stable(SDATA))
        else $error("data moved on the sampling edge");
    a_resync_aux_zero: assert property (@(posedge CLK) disable iff (SRST)
        start && held_kind == K_AUX && resync_sent |-> held_word[31:18] == 14'h0)
        else $error("aux numerator nonzero under resync");
    a_resync_sd_on: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_PHASE && held_word[29] |-> !held_word[30])
        else $error("resync sent with load reset disabled");
    a_adjust_sd_off: assert property (@(posedge CLK) disable iff (SRST)
        start && held_word[3:0] == synth_cfg_pkg::SEL_PHASE && held_word[28] |-> held_word[30])
        else $error("adjust sent with load reset enabled");
    a_word0_mux: assert property (@(posedge CLK) disable iff (SRST)
        start && held_kind == K_WORD0 |-> mux_sent != 3'h3 && mux_sent != 3'h4)
        else $error("word zero sent with divider test output");
endmodule // synth_cfg_host

// [synth_dev_model.sv]
// behavioural synthesizer: serial receiver and control words zero to four
`timescale 1ns/1ps
module synth_dev_model (
    input wire logic sclk,
    input wire logic sdata,
    input wire logic sload
);
    logic [31:0] shift_reg = 32'h0;
    logic [31:0] word_reg [0:4];
    int bit_count = 0;
    int last_bits = 0;
    int load_count = 0;
    int sd_resets = 0;
    logic [23:0] phase_acc = 24'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // decoded reference word, compared by the bench's reference decode check
    wire logic both_edges = word_reg[4][26];
    wire logic cmp_halved = word_reg[4][25];
    wire logic [9:0] ref_ratio = word_reg[4][24:15];
    wire logic divider_buffered = word_reg[4][14];
    wire logic diff_ref = word_reg[4][9];
    wire logic level_high = word_reg[4][8];
    wire logic pump_floating = word_reg[4][5] | word_reg[4][6];
    wire logic counters_held = word_reg[4][4] | word_reg[4][6];
    initial
    begin
        foreach (word_reg[i])
            word_reg[i] = 32'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sclk)
    begin
        shift_reg = {shift_reg[30:0], sdata};
        bit_count = bit_count + 1;
    end
    // registers keep loading in power-down, so no gating here
    always @(posedge sload)
    begin
        last_bits = bit_count;
        bit_count = 0;
        load_count++;
        if (shift_reg[3:0] <= 4'h4)
            word_reg[shift_reg[3:0]] = shift_reg;
        if (shift_reg[3:0] == 4'h0)
        begin
            if (!word_reg[3][30])
                sd_resets++;
            if (word_reg[3][28])
                phase_acc = phase_acc + word_reg[3][27:4];
        end
    end
endmodule // synth_dev_model

// [synth_cfg_host_tb.sv]
// self-checking bench for the control word host
`timescale 1ns/1ps
module synth_cfg_host_tb;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic REQ_VALID = 1'b0;
    logic [2:0] REQ_KIND = 3'h0;
    logic [23:0] MAIN_NUM = 24'h0, MAIN_MOD = 24'h1, PHASE_VAL = 24'h0;
    logic [13:0] AUX_NUM = 14'h0, AUX_MOD = 14'h2;
    logic SD_DIS = 1'b0, RESYNC_EN = 1'b0, ADJ_EN = 1'b0, AUTO_CAL = 1'b0, DOUBLER = 1'b0, HALVER = 1'b0;
    logic DBUF = 1'b0, REF_DIFF = 1'b0, LEVEL_33 = 1'b0, POWER_DOWN = 1'b0, PUMP_TRI = 1'b0, COUNTER_RST = 1'b0;
    logic [2:0] MUX_SEL = 3'h0;
    logic [9:0] REF_COUNT = 10'h001;
    logic [3:0] PUMP_CUR = 4'h0;
    logic [27:0] WORD0_FIELD = 28'h0;
    logic REQ_READY, REQ_DONE, REQ_ERROR, SCLK, SDATA, SLOAD;
    int fails = 0, comparisons = 0, cycles = 0, exp_sd = 0;
    logic [2:0] sh_mux = 3'h0;
    logic [13:0] sh_aux = 14'h0;
    logic sh_adj = 1'b0, sh_sd = 1'b0, sh_rs = 1'b0;
    logic [23:0] sh_phase = 24'h0, exp_acc = 24'h0;
    logic [13:0] aux_mods [6] = '{14'h0, 14'h1, 14'h2, 14'h100, 14'h2, 14'h3FFF};
    logic [13:0] aux_nums [6] = '{14'h0, 14'h0, 14'h0, 14'h100, 14'h1, 14'h3FFE};
    logic [2:0] ph_modes [5] = '{3'h2, 3'h6, 3'h7, 3'h1, 3'h5};
    logic [2:0] mux_codes [3] = '{3'h3, 3'h4, 3'h0};
    synth_cfg_host u_dut (.CLK(CLK), .SRST(SRST), .REQ_VALID(REQ_VALID), .REQ_KIND(REQ_KIND),
        .MAIN_NUM(MAIN_NUM), .MAIN_MOD(MAIN_MOD), .AUX_NUM(AUX_NUM), .AUX_MOD(AUX_MOD), .PHASE_VAL(PHASE_VAL),
        .SD_DIS(SD_DIS), .RESYNC_EN(RESYNC_EN), .ADJ_EN(ADJ_EN), .AUTO_CAL(AUTO_CAL), .MUX_SEL(MUX_SEL),
        .DOUBLER(DOUBLER), .HALVER(HALVER), .REF_COUNT(REF_COUNT), .DBUF(DBUF), .PUMP_CUR(PUMP_CUR),
        .REF_DIFF(REF_DIFF), .LEVEL_33(LEVEL_33), .POWER_DOWN(POWER_DOWN), .PUMP_TRI(PUMP_TRI),
        .COUNTER_RST(COUNTER_RST), .WORD0_FIELD(WORD0_FIELD), .REQ_READY(REQ_READY), .REQ_DONE(REQ_DONE),
        .REQ_ERROR(REQ_ERROR), .SCLK(SCLK), .SDATA(SDATA), .SLOAD(SLOAD));
    synth_dev_model u_dev (.sclk(SCLK), .sdata(SDATA), .sload(SLOAD));
    initial
    begin
        forever #5 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // a hung handshake ends here; 38 requests, each accepted one some 200 cycles
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    function automatic logic refused(input logic [2:0] k);
        case (k)
            3'h0: return sh_mux == 3'h3 || sh_mux == 3'h4 || (sh_adj && AUTO_CAL);
            3'h1: return MAIN_NUM >= MAIN_MOD;
            3'h2: return AUX_MOD < 14'h2 || AUX_NUM >= AUX_MOD || (sh_rs && AUX_NUM != 14'h0);
            3'h3: return (RESYNC_EN && (SD_DIS || ADJ_EN || sh_aux != 14'h0)) || (ADJ_EN && !SD_DIS);
            3'h4: return REF_COUNT == 10'h0;
            default: return 1'b1;
        endcase
    endfunction
    function automatic logic [31:0] word_of(input logic [2:0] k);
        case (k)
            3'h0: return {WORD0_FIELD, 4'h0};
            3'h1: return {4'h0, MAIN_NUM, 4'h1};
            3'h2: return {AUX_NUM, AUX_MOD, 4'h2};
            3'h3: return {1'b0, SD_DIS, RESYNC_EN, ADJ_EN, PHASE_VAL, 4'h3};
            default: return {2'h0, MUX_SEL, DOUBLER, HALVER, REF_COUNT, DBUF, PUMP_CUR, REF_DIFF, LEVEL_33, 1'b1,
                POWER_DOWN, PUMP_TRI, COUNTER_RST, 4'h4};
        endcase
    endfunction
    // one request, valid for one cycle once ready, then compared against the device model
    task automatic req(input logic [2:0] k);
        logic err;
        logic [31:0] w;
        int loads;
        int n;
        logic [31:0] dec;
        logic [31:0] xdec;
        err = refused(k);
        w = word_of(k);
        loads = u_dev.load_count;
        n = 0;
        @(negedge CLK);
        while (REQ_READY !== 1'b1 && n < 1000)
        begin
            @(negedge CLK);
            n++;
        end
        REQ_KIND = k;
        REQ_VALID = 1'b1;
        @(negedge CLK);
        REQ_VALID = 1'b0;
        n = 0;
        while (REQ_DONE !== 1'b1 && n < 1000)
        begin
            @(negedge CLK);
            n++;
        end
        check(32'(REQ_DONE), 32'h1, "done");
        check(32'(REQ_ERROR), 32'(err), "refusal");
        @(negedge CLK);
        if (err)
            check(32'(u_dev.load_count - loads), 32'h0, "load on refusal");
        else
        begin
            check(32'(u_dev.load_count - loads), 32'h1, "load count");
            check(32'(u_dev.last_bits), 32'h20, "bit count");
            check(u_dev.word_reg[k], w, "word");
            if (k == 3'h4)
            begin
                dec = 32'({u_dev.both_edges, u_dev.cmp_halved, u_dev.ref_ratio, u_dev.divider_buffered,
                    u_dev.diff_ref, u_dev.level_high, u_dev.pump_floating, u_dev.counters_held});
                xdec = 32'({DOUBLER, HALVER, REF_COUNT, DBUF, REF_DIFF, LEVEL_33, PUMP_TRI | POWER_DOWN,
                    COUNTER_RST | POWER_DOWN});
                check(dec, xdec, "reference decode");
            end
            if (k == 3'h0 && sh_adj)
                exp_acc = exp_acc + sh_phase;
            if (k == 3'h0 && !sh_sd)
                exp_sd++;
            if (k == 3'h2)
                sh_aux = AUX_NUM;
            if (k == 3'h3)
                {sh_sd, sh_rs, sh_adj, sh_phase} = {SD_DIS, RESYNC_EN, ADJ_EN, PHASE_VAL};
            if (k == 3'h4)
                sh_mux = MUX_SEL;
        end
        check(32'(u_dev.phase_acc), 32'(exp_acc), "phase sum");
        check(32'(u_dev.sd_resets), 32'(exp_sd), "modulator resets");
    endtask
    task automatic end_test(input string name);
        $display("test %s ended, mismatches so far %0d", name, fails);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hF711));
        repeat (6) @(negedge CLK);
        check(32'({SCLK, SDATA, SLOAD, REQ_DONE, REQ_ERROR, REQ_READY}), 32'h0, "outputs in reset");
        SRST = 1'b0;
        repeat (2) @(negedge CLK);
        check(32'(REQ_READY), 32'h1, "ready after reset");
        end_test("reset");
        repeat (4)
        begin
            {MUX_SEL, DOUBLER, HALVER, DBUF, PUMP_CUR, REF_DIFF, LEVEL_33, POWER_DOWN, PUMP_TRI, COUNTER_RST} =
                15'($urandom);
            REF_COUNT = 10'($urandom) | 10'h1;
            req(3'h4);
        end
        REF_COUNT = 10'h0;
        req(3'h4);
        {REF_COUNT, MUX_SEL, POWER_DOWN} = {10'h3FF, 3'h0, 1'b1};
        req(3'h4);
        end_test("reference word");
        repeat (3)
        begin
            MAIN_MOD = 24'($urandom) | 24'h2;
            MAIN_NUM = 24'($urandom) % MAIN_MOD;
            req(3'h1);
        end
        MAIN_NUM = MAIN_MOD;
        req(3'h1);
        {MAIN_NUM, MAIN_MOD} = {24'hFFFFFE, 24'hFFFFFF};
        req(3'h1);
        end_test("main fraction");
        foreach (aux_mods[i])
        begin
            {AUX_MOD, AUX_NUM} = {aux_mods[i], aux_nums[i]};
            req(3'h2);
        end
        end_test("aux word");
        foreach (ph_modes[i])
        begin
            {SD_DIS, RESYNC_EN, ADJ_EN} = ph_modes[i];
            PHASE_VAL = 24'($urandom);
            req(3'h3);
        end
        repeat (2)
        begin
            WORD0_FIELD = 28'($urandom);
            req(3'h0);
        end
        AUTO_CAL = 1'b1;
        req(3'h0);
        AUTO_CAL = 1'b0;
        end_test("phase adjust");
        foreach (mux_codes[i])
        begin
            MUX_SEL = mux_codes[i];
            req(3'h4);
            req(3'h0);
        end
        {AUX_NUM, AUX_MOD} = {14'h0, 14'h5};
        req(3'h2);
        {SD_DIS, RESYNC_EN, ADJ_EN} = 3'h2;
        req(3'h3);
        req(3'h0);
        {AUX_NUM, AUX_MOD} = {14'h1, 14'h5};
        req(3'h2);
        for (int k = 5; k < 8; k++)
            req(3'(k));
        end_test("word zero and codes");
        complete_run();
    end
endmodule // synth_cfg_host_tb
